// >>> rtl/rss_defs.svh
`ifndef RSS_DEFS_SVH
`define RSS_DEFS_SVH

// register map, word byte addresses
`define RSS_ADDR_CFG        4'h0
`define RSS_ADDR_STATUS     4'h4
`define RSS_ADDR_CAUSE      4'h8
`define RSS_ADDR_WIDTH      4
// configuration word bit positions
`define RSS_CFG_INT_CLR     0
`define RSS_CFG_PUD_DIS     1
`define RSS_CFG_BOD_EN      2
`define RSS_CFG_OSC_LO      3
`define RSS_CFG_OSC_HI      5
`define RSS_CFG_RESET       32'h0000_0000
`define RSS_CFG_MASK        32'h0000_003F
// oscillator mode codes
`define RSS_OSC_LP          3'h0
`define RSS_OSC_XT          3'h1
`define RSS_OSC_HS          3'h2
// timing
`define RSS_CLK_HZ          40000000
`define RSS_PUD_MS          72
`define RSS_PUD_CYCLES      (`RSS_CLK_HZ / 1000 * `RSS_PUD_MS)
`define RSS_OST_COUNT       1024
`define RSS_FILT_CYCLES     4
`define RSS_CNT_W           22
`define RSS_FILT_W          3
`define RSS_OST_W           11

`endif

// >>> rtl/rss_pkg.sv
package rss_pkg;
  typedef enum logic [2:0] {
    RSS_HOLD,
    RSS_PUD,
    RSS_OST,
    RSS_RUN
  } rss_state_type;
endpackage

// >>> rtl/rss_sequencer.sv
// Implementation choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "rss_defs.svh"

module rss_sequencer #(
  parameter int PUD_CYCLES = `RSS_PUD_CYCLES
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RESET_N,
  input  wire logic        MASTER_CLEAR_PIN_N,
  input  wire logic        SUPPLY_GOOD,
  input  wire logic        BROWNOUT_OK,
  input  wire logic        WATCHDOG_TIMER_RESET,
  input  wire logic        SLEEP_WAKE,
  input  wire logic        OSCILLATOR_INPUT_PIN,
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  output logic             MASTER_CLEAR_PIN_OE,
  output logic             CORE_RESET
);

  // configuration and bus state
  logic [31:0] cfg_r, cfg_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        ack_r, ack_nxt;
  logic [2:0]  cause_r, cause_nxt;
  // filter, edge and sequence state
  logic [`RSS_FILT_W-1:0] filt_cnt_r, filt_cnt_nxt;
  logic        clr_filt_r, clr_filt_nxt;
  logic        sup_d_r, sup_d_nxt;
  logic        bod_d_r, bod_d_nxt;
  logic        osc_d_r, osc_d_nxt;
  logic [`RSS_CNT_W-1:0] pud_cnt_r, pud_cnt_nxt;
  logic [`RSS_OST_W-1:0] ost_cnt_r, ost_cnt_nxt;
  logic        need_pud_r, need_pud_nxt;
  logic        need_ost_r, need_ost_nxt;
  rss_pkg::rss_state_type st_r, st_nxt;
  logic        core_rst_r, core_rst_nxt;
  // registered bus wait and pin enable outputs
  logic        wait_r;
  logic        oe_r;

  logic [2:0] osc_mode;
  logic       xtal_mode;
  logic       clr_active;
  logic       bod_active;
  logic       por_event;
  logic       bod_event;
  logic       hold_src;

  assign osc_mode  = cfg_r[`RSS_CFG_OSC_HI:`RSS_CFG_OSC_LO];
  assign xtal_mode = (osc_mode == `RSS_OSC_LP) ||
                     (osc_mode == `RSS_OSC_XT) ||
                     (osc_mode == `RSS_OSC_HS);
  // internal select ties clear to supply
  assign clr_active = !cfg_r[`RSS_CFG_INT_CLR] && clr_filt_r;
  assign bod_active = cfg_r[`RSS_CFG_BOD_EN] && !BROWNOUT_OK;
  // only a rising supply makes a power-on event
  assign por_event = SUPPLY_GOOD && !sup_d_r;
  assign bod_event = cfg_r[`RSS_CFG_BOD_EN] && BROWNOUT_OK && !bod_d_r;
  assign hold_src  = !SUPPLY_GOOD || bod_active || clr_active
                     || WATCHDOG_TIMER_RESET;

  // clear pin noise filter: level must persist to switch
  always_comb begin
    filt_cnt_nxt = '0;
    clr_filt_nxt = clr_filt_r;
    if (!MASTER_CLEAR_PIN_N != clr_filt_r) begin
      filt_cnt_nxt = filt_cnt_r + 1'b1;
      if (filt_cnt_r == `RSS_FILT_W'(`RSS_FILT_CYCLES - 1)) begin
        clr_filt_nxt = !MASTER_CLEAR_PIN_N;
        filt_cnt_nxt = '0;
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      filt_cnt_r <= '0;
      clr_filt_r <= 1'b0;
    end else begin
      filt_cnt_r <= filt_cnt_nxt;
      clr_filt_r <= clr_filt_nxt;
    end
  end

  // reset sequence: hold, power-up delay, oscillator count, run
  always_comb begin
    st_nxt       = st_r;
    pud_cnt_nxt  = pud_cnt_r;
    ost_cnt_nxt  = ost_cnt_r;
    need_pud_nxt = need_pud_r || por_event || bod_event;
    need_ost_nxt = need_ost_r || por_event || SLEEP_WAKE;
    cause_nxt    = cause_r;
    sup_d_nxt    = SUPPLY_GOOD;
    bod_d_nxt    = BROWNOUT_OK;
    osc_d_nxt    = OSCILLATOR_INPUT_PIN;
    if (por_event) cause_nxt[0] = 1'b1;
    if (bod_event) cause_nxt[1] = 1'b1;
    if (WATCHDOG_TIMER_RESET) cause_nxt[2] = 1'b1;
    if (hold_src) begin
      st_nxt = rss_pkg::RSS_HOLD;
    end else begin
      unique case (st_r)
        rss_pkg::RSS_HOLD: begin
          pud_cnt_nxt = '0;
          ost_cnt_nxt = '0;
          if (need_pud_nxt && !cfg_r[`RSS_CFG_PUD_DIS])
            st_nxt = rss_pkg::RSS_PUD;
          else if (need_ost_nxt && xtal_mode)
            st_nxt = rss_pkg::RSS_OST;
          else
            st_nxt = rss_pkg::RSS_RUN;
          need_pud_nxt = 1'b0;
        end
        rss_pkg::RSS_PUD: begin
          pud_cnt_nxt = pud_cnt_r + 1'b1;
          if (pud_cnt_r == `RSS_CNT_W'(PUD_CYCLES - 1)) begin
            if (need_ost_r && xtal_mode)
              st_nxt = rss_pkg::RSS_OST;
            else
              st_nxt = rss_pkg::RSS_RUN;
          end
        end
        rss_pkg::RSS_OST: begin
          // count rising edges of the oscillator input
          if (OSCILLATOR_INPUT_PIN && !osc_d_r) begin
            ost_cnt_nxt = ost_cnt_r + 1'b1;
            if (ost_cnt_r == `RSS_OST_W'(`RSS_OST_COUNT - 1))
              st_nxt = rss_pkg::RSS_RUN;
          end
        end
        rss_pkg::RSS_RUN: begin
          need_ost_nxt = 1'b0;
          if (SLEEP_WAKE && xtal_mode) begin
            ost_cnt_nxt = '0;
            st_nxt = rss_pkg::RSS_OST;
          end
        end
        default: st_nxt = rss_pkg::RSS_HOLD;
      endcase
    end
    if (st_nxt == rss_pkg::RSS_OST && st_r != rss_pkg::RSS_OST)
      need_ost_nxt = 1'b0;
    core_rst_nxt = (st_nxt != rss_pkg::RSS_RUN);
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      st_r       <= rss_pkg::RSS_HOLD;
      pud_cnt_r  <= '0;
      ost_cnt_r  <= '0;
      need_pud_r <= 1'b1;
      need_ost_r <= 1'b1;
      cause_r    <= 3'h0;
      sup_d_r    <= 1'b0;
      bod_d_r    <= 1'b0;
      osc_d_r    <= 1'b0;
      core_rst_r <= 1'b1;
    end else begin
      st_r       <= st_nxt;
      pud_cnt_r  <= pud_cnt_nxt;
      ost_cnt_r  <= ost_cnt_nxt;
      need_pud_r <= need_pud_nxt;
      need_ost_r <= need_ost_nxt;
      cause_r    <= cause_nxt;
      sup_d_r    <= sup_d_nxt;
      bod_d_r    <= bod_d_nxt;
      osc_d_r    <= osc_d_nxt;
      core_rst_r <= core_rst_nxt;
    end
  end

  // avalon slave: one wait cycle, then acknowledge
  always_comb begin
    ack_nxt   = 1'b0;
    cfg_nxt   = cfg_r;
    rdata_nxt = rdata_r;
    if ((AVS_READ || AVS_WRITE) && !ack_r) begin
      ack_nxt = 1'b1;
      if (AVS_WRITE && AVS_ADDRESS == `RSS_ADDR_CFG) begin
        for (int i = 0; i < 4; i++) begin
          if (AVS_BYTEENABLE[i])
            cfg_nxt[i*8 +: 8] = AVS_WRITEDATA[i*8 +: 8];
        end
        cfg_nxt = cfg_nxt & `RSS_CFG_MASK;
      end
      unique case (AVS_ADDRESS)
        `RSS_ADDR_CFG:    rdata_nxt = cfg_r;
        `RSS_ADDR_STATUS: rdata_nxt = {26'h000_0000, clr_filt_r,
                                       hold_src, core_rst_r, 3'(st_r)};
        `RSS_ADDR_CAUSE:  rdata_nxt = {29'h0000_0000, cause_r};
        default:          rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      cfg_r   <= `RSS_CFG_RESET;
      rdata_r <= 32'h0000_0000;
      ack_r   <= 1'b0;
      wait_r  <= 1'b1;
      oe_r    <= 1'b0;
    end else begin
      cfg_r   <= cfg_nxt;
      rdata_r <= rdata_nxt;
      ack_r   <= ack_nxt;
      wait_r  <= !ack_nxt;
      // watchdog reset stays internal, pin never driven
      oe_r    <= 1'b0;
    end
  end

  assign AVS_READDATA    = rdata_r;
  assign AVS_WAITREQUEST = wait_r;
  assign MASTER_CLEAR_PIN_OE = oe_r;
  assign CORE_RESET = core_rst_r;

endmodule

// >>> bench/rss_seq_props.sv
`timescale 1ns/1ps
module rss_seq_props (
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic SUPPLY_GOOD,
  input wire logic WATCHDOG_TIMER_RESET,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic AVS_WAITREQUEST,
  input wire logic MASTER_CLEAR_PIN_OE,
  input wire logic CORE_RESET
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  // bus request still waiting for its answer
  sequence s_req;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
  endsequence
  // a supply rise is held in reset
  sequence s_held;
    CORE_RESET [*2];
  endsequence
  property p_oe; MASTER_CLEAR_PIN_OE == 1'h0; endproperty
  property p_sup; !SUPPLY_GOOD |=> CORE_RESET; endproperty
  property p_wdt; WATCHDOG_TIMER_RESET |=> CORE_RESET; endproperty
  property p_rel;
    $fell(CORE_RESET) |-> $past(SUPPLY_GOOD) && !$past(WATCHDOG_TIMER_RESET);
  endproperty
  property p_por; $rose(SUPPLY_GOOD) |-> s_held; endproperty
  property p_ack; s_req |=> !AVS_WAITREQUEST; endproperty
  property p_one; !AVS_WAITREQUEST |=> AVS_WAITREQUEST; endproperty
  property p_cause; $fell(AVS_WAITREQUEST) |-> $past(AVS_READ || AVS_WRITE);
  endproperty
  a_oe: assert property (p_oe) else $error("clear pin driven");
  a_sup: assert property (p_sup) else $error("low supply ignored");
  a_wdt: assert property (p_wdt) else $error("watchdog ignored");
  a_rel: assert property (p_rel) else $error("early release");
  a_por: assert property (p_por) else $error("supply rise free");
  a_ack: assert property (p_ack) else $error("no bus answer");
  a_one: assert property (p_one) else $error("answer too long");
  a_cause: assert property (p_cause) else $error("answer without request");
endmodule

bind rss_sequencer rss_seq_props i_props (
  .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .SUPPLY_GOOD(SUPPLY_GOOD),
  .WATCHDOG_TIMER_RESET(WATCHDOG_TIMER_RESET), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .MASTER_CLEAR_PIN_OE(MASTER_CLEAR_PIN_OE), .CORE_RESET(CORE_RESET));

// >>> bench/rss_ext_model.sv
`timescale 1ns/1ps
module rss_ext_model (
  input  wire logic clk,
  output logic      supply_good,
  output logic      brownout_ok,
  output logic      clear_n,
  output logic      osc
);
  logic [1:0] ph;
  // start with supplies good and pin released
  initial begin
    ph = 2'h0;
    osc = 1'h0;
    supply_good = 1'h1;
    brownout_ok = 1'h1;
    clear_n = 1'h1;
  end
  // free-running crystal, one rising edge every four clocks
  always @(posedge clk) begin
    ph <= ph + 2'h1;
    osc <= ph[1];
  end
  // supply monitor levels change at a clock edge
  task supply(input logic s, input logic b);
    @(posedge clk);
    supply_good <= s;
    brownout_ok <= b;
  endtask
  // clear pin pulled low for n cycles
  task clr(input int n);
    @(posedge clk);
    clear_n <= 1'h0;
    repeat (n) @(posedge clk);
    clear_n <= 1'h1;
  endtask
endmodule

// >>> bench/tb.sv
`timescale 1ns/1ps
`include "rss_defs.svh"
module tb;
  localparam int PUD = 20;
  localparam int OSC_STARTUP_TIMER = 4096;
  logic        clk, rst_n, wdt, wake, rd, wr, wq, sup, bok, clr_n, osc, core;
  logic [3:0]  addr;
  logic [31:0] wd, rdat, v;
  int          miscompares, n_tests, n;
  rss_ext_model i_ext (.clk(clk), .supply_good(sup), .brownout_ok(bok),
    .clear_n(clr_n), .osc(osc));
  rss_sequencer #(.PUD_CYCLES(PUD)) i_dut (.SYS_CLK(clk), .RESET_N(rst_n),
    .MASTER_CLEAR_PIN_N(clr_n), .SUPPLY_GOOD(sup), .BROWNOUT_OK(bok),
    .WATCHDOG_TIMER_RESET(wdt), .SLEEP_WAKE(wake),
    .OSCILLATOR_INPUT_PIN(osc), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hF),
    .AVS_READDATA(rdat), .AVS_WAITREQUEST(wq), .MASTER_CLEAR_PIN_OE(),
    .CORE_RESET(core));
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task results;
    $display("checks %0d errors %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one bus cycle, held until waitrequest is seen low
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do @(posedge clk); while (wq !== 1'h0);
    v = rdat;
    wr <= 1'h0;
    rd <= 1'h0;
  endtask
  // cycles until the core is released, within a window
  task rel(input int lo, input int hi);
    n = 0;
    while (core !== 1'h0 && n < 9000) begin
      @(posedge clk);
      n++;
    end
    chk("release", 32'(n >= lo && n <= hi), 32'h0000_0001);
  endtask
  // one-cycle pulse, then look at the core reset
  task pulse(input logic w);
    @(posedge clk);
    wdt <= w;
    wake <= !w;
    @(posedge clk);
    wdt <= 1'h0;
    wake <= 1'h0;
    @(posedge clk);
    chk("pulse", 32'(core), 32'h0000_0001);
  endtask
  // clock source
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  // hang guard
  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    results;
  end
  // main sequence
  initial begin
    {rst_n, wdt, wake, rd, wr, addr, wd} = '0;
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    rel(PUD + OSC_STARTUP_TIMER - 8, PUD + OSC_STARTUP_TIMER + 40);
    bus(0, `RSS_ADDR_CFG, 32'h0000_0000);
    chk("cfg", v, `RSS_CFG_RESET);
    bus(1, `RSS_ADDR_CFG, 32'hFFFF_FFFF);
    bus(0, `RSS_ADDR_CFG, 32'h0000_0000);
    chk("cfg", v, `RSS_CFG_MASK);
    bus(1, 4'hC, 32'hFFFF_FFFF);
    bus(0, 4'hC, 32'h0000_0000);
    chk("unmapped", v, 32'h0000_0000);
    bus(1, `RSS_ADDR_CFG, 32'h0000_0000);
    i_ext.clr(2);
    repeat (6) @(posedge clk);
    chk("glitch", 32'(core), 32'h0000_0000);
    i_ext.clr(8);
    chk("clear", 32'(core), 32'h0000_0001);
    rel(0, 10);
    bus(1, `RSS_ADDR_CFG, 32'h0000_0001);
    i_ext.clr(8);
    chk("tied", 32'(core), 32'h0000_0000);
    pulse(1);
    rel(0, 10);
    bus(1, `RSS_ADDR_CFG, 32'h0000_001C);
    i_ext.supply(1, 0);
    repeat (3) @(posedge clk);
    chk("brownout", 32'(core), 32'h0000_0001);
    i_ext.supply(1, 1);
    rel(PUD - 2, PUD + 20);
    bus(1, `RSS_ADDR_CFG, 32'h0000_000A);
    i_ext.supply(0, 1);
    repeat (3) @(posedge clk);
    chk("supply", 32'(core), 32'h0000_0001);
    i_ext.supply(1, 1);
    rel(OSC_STARTUP_TIMER - 8, OSC_STARTUP_TIMER + 40);
    pulse(0);
    rel(OSC_STARTUP_TIMER - 8, OSC_STARTUP_TIMER + 40);
    bus(0, `RSS_ADDR_CAUSE, 32'h0000_0000);
    chk("cause", v, 32'h0000_0007);
    bus(0, `RSS_ADDR_STATUS, 32'h0000_0000);
    chk("status", v, 32'h0000_0003);
    results;
  end
endmodule
